// File: hdl/uplink_pkg.sv
// Shared constants and types for uplink lane select and health logic
package uplink_pkg;
   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int          NUM_LANES      = 4;
   localparam int          NUM_CRIT       = 4;
   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 32;
   localparam int          IRQ_W          = 4;
   localparam int          CNT_W          = 32;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0]  OFS_LANE_SEL   = 8'h00;
   localparam logic [7:0]  OFS_HEALTH     = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STAT   = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK   = 8'h0c;
   localparam logic [7:0]  OFS_FW_CTRL    = 8'h10;
   localparam logic [7:0]  OFS_THRESH     = 8'h14;
   localparam logic [7:0]  OFS_HYST       = 8'h18;
   // ---------------------------------------------------------------
   // Reset values and health event code
   // ---------------------------------------------------------------
   localparam logic [3:0]  LANE_SEL_RST   = 4'hc;
   localparam logic [7:0]  THRESH_RST     = 8'h50;
   localparam logic [7:0]  HYST_RST       = 8'h05;
   localparam logic [7:0]  HEALTH_EVT     = 8'h03;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int          HB_OFFSET      = 0;
   localparam int          HB_PAYLOAD     = 1;
   localparam int          HB_GREEN       = 2;
   localparam int          HB_AMBER       = 3;
   localparam int          HB_TEMP        = 4;
   localparam int          HB_EVT_LO      = 8;
   localparam int          IRQ_ERR_SET    = 0;
   localparam int          IRQ_ERR_CLR    = 1;
   localparam int          IRQ_FW_OK      = 2;
   localparam int          IRQ_FW_REVERT  = 3;
   localparam int          FW_START_BIT   = 0;
   localparam int          FW_BUSY_BIT    = 0;
   localparam int          FW_BANK_BIT    = 1;
   localparam int          FW_STATE_LO    = 4;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned BOOT_TMO_MS    = 100;
   localparam int unsigned BOOT_TMO_CYC   = (CLK_HZ / 1000) * BOOT_TMO_MS;
   // ---------------------------------------------------------------
   // Update manager states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      FW_IDLE   = 3'h0,
      FW_WRITE  = 3'h1,
      FW_LOAD   = 3'h3,
      FW_BOOT   = 3'h2,
      FW_REVERT = 3'h6
   } fw_state_t;
endpackage : uplink_pkg

// File: hdl/firmware_update_manager.sv
// Dual bank firmware update manager with boot timeout fallback
`timescale 1ns/1ns
module firmware_update_manager #(
   parameter int unsigned BOOT_TIMEOUT_CYCLES = uplink_pkg::BOOT_TMO_CYC
) (
   input  wire logic                clock_i,
   input  wire logic                rst_b_i,
   input  wire logic                start_i,
   input  wire logic                write_done_i,
   input  wire logic                load_done_i,
   input  wire logic                boot_ack_i,
   output logic                     bank_write_o,
   output logic                     write_bank_o,
   output logic                     ctrl_load_o,
   output logic                     load_bank_o,
   output logic                     ctrl_run_o,
   output logic                     active_bank_o,
   output logic                     busy_o,
   output uplink_pkg::fw_state_t    state_o,
   output logic                     ok_pulse_o,
   output logic                     revert_pulse_o
);
   import uplink_pkg::*;

   localparam logic [CNT_W-1:0] TMO_LAST = CNT_W'(BOOT_TIMEOUT_CYCLES - 1);

   typedef struct packed {
      fw_state_t          state;
      logic               active_bank;
      logic               write_bank;
      logic [CNT_W-1:0]   cnt;
      logic               bank_write;
      logic               ctrl_load;
      logic               load_bank;
      logic               ctrl_run;
      logic               ok;
      logic               revert;
   } fw_regs_t;

   fw_regs_t fw_reg;
   fw_regs_t fw_next;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      fw_next        = fw_reg;
      fw_next.ok     = 1'b0;
      fw_next.revert = 1'b0;
      unique case (fw_reg.state)
         FW_IDLE: begin
            if (start_i) begin
               fw_next.write_bank = ~fw_reg.active_bank;
               fw_next.bank_write = 1'b1;
               fw_next.state      = FW_WRITE;
            end
         end
         FW_WRITE: begin
            if (write_done_i) begin
               fw_next.bank_write = 1'b0;
               fw_next.ctrl_run   = 1'b0;
               fw_next.ctrl_load  = 1'b1;
               fw_next.load_bank  = fw_reg.write_bank;
               fw_next.state      = FW_LOAD;
            end
         end
         FW_LOAD: begin
            if (load_done_i) begin
               fw_next.ctrl_load = 1'b0;
               fw_next.ctrl_run  = 1'b1;
               fw_next.cnt       = '0;
               fw_next.state     = FW_BOOT;
            end
         end
         FW_BOOT: begin
            if (boot_ack_i) begin
               fw_next.active_bank = fw_reg.write_bank;
               fw_next.ok          = 1'b1;
               fw_next.state       = FW_IDLE;
            end else if (fw_reg.cnt == TMO_LAST) begin
               fw_next.ctrl_run  = 1'b0;
               fw_next.ctrl_load = 1'b1;
               fw_next.load_bank = fw_reg.active_bank;
               fw_next.revert    = 1'b1;
               fw_next.state     = FW_REVERT;
            end else begin
               fw_next.cnt = fw_reg.cnt + 1'b1;
            end
         end
         FW_REVERT: begin
            if (load_done_i) begin
               fw_next.ctrl_load = 1'b0;
               fw_next.ctrl_run  = 1'b1;
               fw_next.state     = FW_IDLE;
            end
         end
         default: begin
            fw_next.state = FW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         fw_reg          <= '0;
         fw_reg.state    <= FW_IDLE;
         fw_reg.ctrl_run <= 1'b1;
      end else begin
         fw_reg <= fw_next;
      end
   end

   assign bank_write_o   = fw_reg.bank_write;
   assign write_bank_o   = fw_reg.write_bank;
   assign ctrl_load_o    = fw_reg.ctrl_load;
   assign load_bank_o    = fw_reg.load_bank;
   assign ctrl_run_o     = fw_reg.ctrl_run;
   assign active_bank_o  = fw_reg.active_bank;
   assign busy_o         = (fw_reg.state != FW_IDLE);
   assign state_o        = fw_reg.state;
   assign ok_pulse_o     = fw_reg.ok;
   assign revert_pulse_o = fw_reg.revert;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking fw_cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   a_write_other_bank: assert property (fw_reg.state == FW_IDLE && start_i
      |=> bank_write_o && write_bank_o != active_bank_o)
      else $error("new image not written to the spare bank");
   a_revert_on_tmo: assert property (fw_reg.state == FW_BOOT && !boot_ack_i && fw_reg.cnt == TMO_LAST
      |=> revert_pulse_o && ctrl_load_o && load_bank_o == active_bank_o)
      else $error("timeout did not reload the old bank");
   a_boot_ok_bank: assert property (fw_reg.state == FW_BOOT && boot_ack_i
      |=> ok_pulse_o && active_bank_o == $past(fw_reg.write_bank))
      else $error("acknowledged boot did not adopt new bank");
   c_fw_ok: cover property (fw_reg.state == FW_BOOT && boot_ack_i);
   c_fw_revert: cover property (fw_reg.state == FW_REVERT && load_done_i);
endmodule : firmware_update_manager

// File: hdl/uplink_lane_select_health.sv
// Uplink lane selectors, health indicator, update manager and APB registers
`timescale 1ns/1ns
module uplink_lane_select_health #(
   parameter int unsigned NUM_LANES           = uplink_pkg::NUM_LANES,
   parameter int unsigned NUM_CRIT            = uplink_pkg::NUM_CRIT,
   parameter int unsigned BOOT_TIMEOUT_CYCLES = uplink_pkg::BOOT_TMO_CYC
) (
   input  wire logic                          clock_i,
   input  wire logic                          rst_b_i,
   input  wire logic                          psel_i,
   input  wire logic                          penable_i,
   input  wire logic                          pwrite_i,
   input  wire logic [uplink_pkg::ADDR_W-1:0] paddr_i,
   input  wire logic [uplink_pkg::DATA_W-1:0] pwdata_i,
   output logic      [uplink_pkg::DATA_W-1:0] prdata_o,
   output logic                               pready_o,
   output logic                               pslverr_o,
   input  wire logic [NUM_CRIT-1:0]           critical_i,
   input  wire logic [7:0]                    temp_i,
   input  wire logic                          payload_on_i,
   input  wire logic [NUM_LANES-1:0]          uplink_tx_i,
   input  wire logic [NUM_LANES-1:0]          port_a_rx_i,
   input  wire logic [NUM_LANES-1:0]          port_b_rx_i,
   output logic      [NUM_LANES-1:0]          port_a_tx_o,
   output logic      [NUM_LANES-1:0]          port_b_tx_o,
   output logic      [NUM_LANES-1:0]          uplink_rx_o,
   output logic      [NUM_LANES-1:0]          lane_sel_o,
   output logic                               health_green_o,
   output logic                               health_amber_o,
   output logic                               health_err_o,
   output logic                               irq_o,
   input  wire logic                          write_done_i,
   input  wire logic                          load_done_i,
   input  wire logic                          boot_ack_i,
   output logic                               bank_write_o,
   output logic                               write_bank_o,
   output logic                               ctrl_load_o,
   output logic                               load_bank_o,
   output logic                               ctrl_run_o
);
   import uplink_pkg::*;

   typedef struct packed {
      logic [NUM_LANES-1:0] lane_sel;
      logic [NUM_LANES-1:0] port_a_tx;
      logic [NUM_LANES-1:0] port_b_tx;
      logic [NUM_LANES-1:0] uplink_rx;
      logic [7:0]           thresh;
      logic [7:0]           hyst;
      logic                 temp_over;
      logic                 health_err;
      logic                 green;
      logic                 amber;
      logic [IRQ_W-1:0]     irq_stat;
      logic [IRQ_W-1:0]     irq_mask;
      logic                 irq;
      logic                 pready;
      logic                 pslverr;
      logic [DATA_W-1:0]    prdata;
      logic                 fw_start;
   } top_regs_t;

   top_regs_t top_reg;
   top_regs_t top_next;

   logic [NUM_LANES-1:0] route_a;
   logic [NUM_LANES-1:0] route_b;
   logic [NUM_LANES-1:0] route_rx;
   logic                 fw_busy;
   logic                 fw_active_bank;
   fw_state_t            fw_state;
   logic                 fw_ok;
   logic                 fw_revert;

   // ---------------------------------------------------------------
   // Lane selectors
   // ---------------------------------------------------------------
   genvar lane;
   generate
      for (lane = 0; lane < NUM_LANES; lane++) begin : g_lane
         // Port A side is P0,P1,P20,P4; port B side is P11,P10,P9,P8
         assign route_a[lane]  = uplink_tx_i[lane] & ~top_reg.lane_sel[lane];
         assign route_b[lane]  = uplink_tx_i[lane] & top_reg.lane_sel[lane];
         assign route_rx[lane] = top_reg.lane_sel[lane] ? port_b_rx_i[lane] : port_a_rx_i[lane];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Update manager
   // ---------------------------------------------------------------
   firmware_update_manager #(
      .BOOT_TIMEOUT_CYCLES (BOOT_TIMEOUT_CYCLES)
   ) u_fw (
      .clock_i        (clock_i),
      .rst_b_i        (rst_b_i),
      .start_i        (top_reg.fw_start),
      .write_done_i   (write_done_i),
      .load_done_i    (load_done_i),
      .boot_ack_i     (boot_ack_i),
      .bank_write_o   (bank_write_o),
      .write_bank_o   (write_bank_o),
      .ctrl_load_o    (ctrl_load_o),
      .load_bank_o    (load_bank_o),
      .ctrl_run_o     (ctrl_run_o),
      .active_bank_o  (fw_active_bank),
      .busy_o         (fw_busy),
      .state_o        (fw_state),
      .ok_pulse_o     (fw_ok),
      .revert_pulse_o (fw_revert)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic              access;
      logic              commit;
      logic              hit;
      logic [DATA_W-1:0] rd;
      logic [IRQ_W-1:0]  w1c;
      logic [IRQ_W-1:0]  events;
      logic [8:0]        low_band;
      access   = 1'b0;
      commit   = 1'b0;
      hit      = 1'b0;
      rd       = '0;
      w1c      = '0;
      events   = '0;
      low_band = '0;
      top_next = top_reg;
      top_next.fw_start  = 1'b0;
      top_next.port_a_tx = route_a;
      top_next.port_b_tx = route_b;
      top_next.uplink_rx = route_rx;

      // Temperature sensor with threshold and hysteresis band
      low_band = {1'b0, temp_i} + {1'b0, top_reg.hyst};
      if (temp_i > top_reg.thresh) begin
         top_next.temp_over = 1'b1;
      end else if (low_band < {1'b0, top_reg.thresh}) begin
         top_next.temp_over = 1'b0;
      end

      // Health aggregation and indicator
      top_next.health_err = (|critical_i) | top_reg.temp_over;
      top_next.green      = payload_on_i & ~top_next.health_err;
      top_next.amber      = payload_on_i & top_next.health_err;

      // APB decode
      access = psel_i & penable_i & ~top_reg.pready;
      commit = psel_i & penable_i & top_reg.pready;
      unique case (paddr_i)
         OFS_LANE_SEL: begin
            hit = 1'b1;
            rd[NUM_LANES-1:0] = top_reg.lane_sel;
         end
         OFS_HEALTH: begin
            hit = 1'b1;
            rd[HB_OFFSET]               = top_reg.health_err;
            rd[HB_PAYLOAD]              = payload_on_i;
            rd[HB_GREEN]                = top_reg.green;
            rd[HB_AMBER]                = top_reg.amber;
            rd[HB_TEMP]                 = top_reg.temp_over;
            rd[HB_EVT_LO +: 8]          = HEALTH_EVT;
         end
         OFS_IRQ_STAT: begin
            hit = 1'b1;
            rd[IRQ_W-1:0] = top_reg.irq_stat;
         end
         OFS_IRQ_MASK: begin
            hit = 1'b1;
            rd[IRQ_W-1:0] = top_reg.irq_mask;
         end
         OFS_FW_CTRL: begin
            hit = 1'b1;
            rd[FW_BUSY_BIT]        = fw_busy;
            rd[FW_BANK_BIT]        = fw_active_bank;
            rd[FW_STATE_LO +: 3]   = fw_state;
         end
         OFS_THRESH: begin
            hit = 1'b1;
            rd[7:0] = top_reg.thresh;
         end
         OFS_HYST: begin
            hit = 1'b1;
            rd[7:0] = top_reg.hyst;
         end
         default: begin
            hit = 1'b0;
         end
      endcase

      if (access) begin
         top_next.pready  = 1'b1;
         top_next.pslverr = ~hit;
         top_next.prdata  = pwrite_i ? '0 : rd;
      end else if (commit) begin
         top_next.pready  = 1'b0;
         top_next.pslverr = 1'b0;
         top_next.prdata  = '0;
         if (pwrite_i) begin
            unique case (paddr_i)
               OFS_LANE_SEL: begin
                  top_next.lane_sel = pwdata_i[NUM_LANES-1:0];
               end
               OFS_IRQ_STAT: begin
                  w1c = pwdata_i[IRQ_W-1:0];
               end
               OFS_IRQ_MASK: begin
                  top_next.irq_mask = pwdata_i[IRQ_W-1:0];
               end
               OFS_FW_CTRL: begin
                  top_next.fw_start = pwdata_i[FW_START_BIT] & ~fw_busy;
               end
               OFS_THRESH: begin
                  top_next.thresh = pwdata_i[7:0];
               end
               OFS_HYST: begin
                  top_next.hyst = pwdata_i[7:0];
               end
               default: begin
                  top_next.pslverr = 1'b0;
               end
            endcase
         end
      end

      // Sticky events, set beats clear
      events[IRQ_ERR_SET]   = top_next.health_err & ~top_reg.health_err;
      events[IRQ_ERR_CLR]   = ~top_next.health_err & top_reg.health_err;
      events[IRQ_FW_OK]     = fw_ok;
      events[IRQ_FW_REVERT] = fw_revert;
      top_next.irq_stat = (top_reg.irq_stat & ~w1c) | events;
      top_next.irq      = |(top_next.irq_stat & top_next.irq_mask);
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         top_reg          <= '0;
         top_reg.lane_sel <= LANE_SEL_RST;
         top_reg.thresh   <= THRESH_RST;
         top_reg.hyst     <= HYST_RST;
      end else begin
         top_reg <= top_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata_o       = top_reg.prdata;
   assign pready_o       = top_reg.pready;
   assign pslverr_o      = top_reg.pslverr;
   assign port_a_tx_o    = top_reg.port_a_tx;
   assign port_b_tx_o    = top_reg.port_b_tx;
   assign uplink_rx_o    = top_reg.uplink_rx;
   assign lane_sel_o     = top_reg.lane_sel;
   assign health_green_o = top_reg.green;
   assign health_amber_o = top_reg.amber;
   assign health_err_o   = top_reg.health_err;
   assign irq_o          = top_reg.irq;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking top_cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   logic commit_w;
   assign commit_w = psel_i & penable_i & top_reg.pready;

   a_err_any_sensor: assert property ((|critical_i) |=> health_err_o)
      else $error("critical sensor did not raise health error");
   a_health_green: assert property (payload_on_i && !(|critical_i) && !top_reg.temp_over
      |=> health_green_o && !health_amber_o)
      else $error("indicator not green in normal state");
   a_health_amber: assert property (payload_on_i && (|critical_i) |=> health_amber_o && !health_green_o)
      else $error("indicator not amber on sensor fault");
   a_health_off: assert property (!payload_on_i |=> !health_green_o && !health_amber_o)
      else $error("indicator lit with payload off");
   a_lane_route: assert property (1'b1 |=> port_a_tx_o == $past(uplink_tx_i & ~lane_sel_o)
      && port_b_tx_o == $past(uplink_tx_i & lane_sel_o))
      else $error("uplink routed to wrong port");
   a_lane_reset: assert property (disable iff (1'b0) !rst_b_i |=> lane_sel_o == LANE_SEL_RST)
      else $error("lane select reset value wrong");
   a_lane_hold: assert property (!(commit_w && pwrite_i && paddr_i == OFS_LANE_SEL)
      |=> $stable(lane_sel_o))
      else $error("lane select changed without a command");
   a_irq_level: assert property (1'b1 |-> irq_o == |(top_reg.irq_stat & top_reg.irq_mask))
      else $error("interrupt level mismatch");
   a_thresh_reset: assert property (disable iff (1'b0) !rst_b_i |=> top_reg.thresh == THRESH_RST)
      else $error("threshold not at built-in value");

   // ---------------------------------------------------------------
   // Bus, routing and health checks
   // ---------------------------------------------------------------
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");

   a_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("access not answered after one wait");

   a_unmapped_err: assert property (psel_i && penable_i && !pready_o && paddr_i > OFS_HYST
      |=> pslverr_o && prdata_o == '0)
      else $error("unmapped access not refused");

   a_health_code: assert property (psel_i && penable_i && !pready_o && !pwrite_i && paddr_i == OFS_HEALTH
      |=> prdata_o[HB_EVT_LO +: 8] == HEALTH_EVT && prdata_o[HB_OFFSET] == $past(health_err_o))
      else $error("health reading wrong");

   a_lane_write: assert property (commit_w && pwrite_i && paddr_i == OFS_LANE_SEL
      |=> lane_sel_o == $past(pwdata_i[NUM_LANES-1:0]))
      else $error("lane select command not applied");

   a_rx_route: assert property (1'b1 |=> uplink_rx_o
      == $past(port_b_rx_i & lane_sel_o | port_a_rx_i & ~lane_sel_o))
      else $error("port data routed to wrong uplink");

   a_temp_over: assert property (temp_i > top_reg.thresh |=> top_reg.temp_over)
      else $error("temperature above threshold not flagged");

   a_err_clear: assert property (!(|critical_i) && !top_reg.temp_over |=> !health_err_o)
      else $error("health error without a cause");

   c_lane_write: cover property (commit_w && pwrite_i && paddr_i == OFS_LANE_SEL);
   c_amber: cover property (health_amber_o);
   c_irq: cover property (irq_o);
endmodule : uplink_lane_select_health

// File: tb/mgmt_side_model.sv
// Model of image banks and controller start-up
`timescale 1ns/1ns
module mgmt_side_model (
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   input  wire logic bank_write_i,
   input  wire logic ctrl_load_i,
   input  wire logic ctrl_run_i,
   input  wire logic ack_en_i,
   input  wire logic slow_i,
   output logic      write_done_o,
   output logic      load_done_o,
   output logic      boot_ack_o
);
   logic [3:0] cnt;
   logic       loaded;
   always @(posedge clock_i) begin
      write_done_o <= 1'b0;
      load_done_o  <= 1'b0;
      boot_ack_o   <= 1'b0;
      if (!rst_b_i) begin
         cnt    <= 4'h0;
         loaded <= 1'b0;
      end else if (bank_write_i | ctrl_load_i) begin
         cnt <= cnt + 4'h1;
         if (cnt == (slow_i ? 4'h6 : 4'h1)) begin
            write_done_o <= bank_write_i;
            load_done_o  <= ctrl_load_i;
            loaded       <= ctrl_load_i;
            cnt          <= 4'h0;
         end
      end else if (ctrl_run_i & loaded) begin
         cnt <= cnt + 4'h1;
         if (ack_en_i && cnt == (slow_i ? 4'h9 : 4'h2)) begin
            boot_ack_o <= 1'b1;
            loaded     <= 1'b0;
            cnt        <= 4'h0;
         end
      end
   end
endmodule : mgmt_side_model

// File: tb/uplink_lane_select_health_bench.sv
// Self-checking bench for uplink lane select and health block
`timescale 1ns/1ns
module uplink_lane_select_health_bench;
   import uplink_pkg::*;
   logic        clock_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, payload_on_i = 0;
   logic        pready_o, pslverr_o, health_green_o, health_amber_o, health_err_o, irq_o, ack_en = 1, slow = 1;
   logic        write_done_i, load_done_i, boot_ack_i, bank_write_o, write_bank_o, ctrl_load_o, load_bank_o;
   logic        ctrl_run_o;
   logic [7:0]  paddr_i = 0, temp_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, d;
   logic [3:0]  critical_i = 0, uplink_tx_i = 0, port_a_rx_i = 0, port_b_rx_i = 0;
   logic [3:0]  port_a_tx_o, port_b_tx_o, uplink_rx_o, lane_sel_o;
   logic [32:0] q[$];
   integer      seed = 32'h152b, mismatches = 0, tests_run = 0, i, k;
   uplink_lane_select_health #(.BOOT_TIMEOUT_CYCLES(20)) u_dut (.clock_i, .rst_b_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .critical_i, .temp_i, .payload_on_i,
      .uplink_tx_i, .port_a_rx_i, .port_b_rx_i, .port_a_tx_o, .port_b_tx_o, .uplink_rx_o, .lane_sel_o,
      .health_green_o, .health_amber_o, .health_err_o, .irq_o, .write_done_i, .load_done_i, .boot_ack_i,
      .bank_write_o, .write_bank_o, .ctrl_load_o, .load_bank_o, .ctrl_run_o);
   mgmt_side_model u_far (.clock_i, .rst_b_i, .bank_write_i(bank_write_o), .ctrl_load_i(ctrl_load_o),
      .ctrl_run_i(ctrl_run_o), .ack_en_i(ack_en), .slow_i(slow), .write_done_o(write_done_i),
      .load_done_o(load_done_i), .boot_ack_o(boot_ack_i));
   always #10 clock_i = ~clock_i;
   task check(input logic [32:0] seen, input logic [32:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask : tick
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] e);
      @(posedge clock_i);
      q.push_back(e);
      psel_i   <= 1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= wd;
      @(posedge clock_i);
      penable_i <= 1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      psel_i    <= 0;
      penable_i <= 0;
   endtask : apb
   task results();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   always @(posedge clock_i)
      if (pready_o === 1'b1)
         check({pslverr_o, prdata_o}, q.pop_front());
   initial begin
      #400000;
      mismatches++;
      results();
   end
   initial begin
      tick(6);
      rst_b_i <= 1;
      check(lane_sel_o, 4'hc);
      apb(0, OFS_LANE_SEL, 0, 33'hc);
      apb(0, OFS_THRESH, 0, 33'h50);
      apb(0, OFS_HYST, 0, 33'h05);
      d = $random(seed);
      apb(1, OFS_THRESH, d, 0);
      apb(0, OFS_THRESH, 0, d[7:0]);
      apb(0, 8'h40, 0, 33'h100000000);
      $display("register test done");
      for (i = 0; i < 6; i++) begin
         d = $random(seed);
         apb(1, OFS_LANE_SEL, d, 0);
         uplink_tx_i <= d[7:4];
         port_a_rx_i <= d[11:8];
         port_b_rx_i <= d[15:12];
         tick(2);
         check(lane_sel_o, d[3:0]);
         check({port_b_tx_o, port_a_tx_o}, {d[7:4] & d[3:0], d[7:4] & ~d[3:0]});
         check(uplink_rx_o, (d[15:12] & d[3:0]) | (d[11:8] & ~d[3:0]));
      end
      $display("lane test done");
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         critical_i   <= (i < 2) ? 4'h0 : d[3:0];
         payload_on_i <= i[0];
         tick(2);
         check(health_err_o, |critical_i);
         check(health_green_o, payload_on_i & ~|critical_i);
         check(health_amber_o, payload_on_i & |critical_i);
      end
      apb(0, OFS_HEALTH, 0, {24'h3, 4'h0, payload_on_i & |critical_i, payload_on_i & ~|critical_i,
         payload_on_i, |critical_i});
      critical_i <= 4'h0;
      tick(3);
      apb(1, OFS_IRQ_STAT, 32'hf, 0);
      apb(1, OFS_IRQ_MASK, 32'h1, 0);
      critical_i <= 4'h2;
      tick(3);
      check(irq_o, 1'b1);
      apb(0, OFS_IRQ_STAT, 0, 33'h1);
      apb(1, OFS_IRQ_MASK, 32'h0, 0);
      tick(2);
      check(irq_o, 1'b0);
      critical_i <= 4'h0;
      tick(3);
      apb(0, OFS_IRQ_STAT, 0, 33'h3);
      apb(1, OFS_THRESH, 32'h50, 0);
      for (i = 0; i < 3; i++) begin
         temp_i <= (i == 0) ? 8'h60 : (i == 1) ? 8'h4c : 8'h40;
         tick(3);
         check(health_err_o, i < 2);
      end
      apb(1, OFS_IRQ_STAT, 32'hf, 0);
      apb(0, OFS_IRQ_STAT, 0, 33'h0);
      $display("health test done");
      apb(1, OFS_IRQ_MASK, 32'hc, 0);
      for (i = 0; i < 2; i++) begin
         ack_en <= (i == 0);
         slow   <= (i == 0);
         apb(1, OFS_FW_CTRL, 32'h1, 0);
         for (k = 0; k < 9 && bank_write_o !== 1'b1; k++) tick(1);
         check(bank_write_o, 1'b1);
         check(write_bank_o, !i[0]);
         for (k = 0; k < 400 && irq_o !== 1'b1; k++) tick(1);
         check(irq_o, 1'b1);
         for (k = 0; k < 20 && ctrl_run_o !== 1'b1; k++) tick(1);
         check({ctrl_load_o, load_bank_o, ctrl_run_o}, 3'h3);
         apb(0, OFS_IRQ_STAT, 0, i ? 33'h8 : 33'h4);
         apb(0, OFS_FW_CTRL, 0, 33'h2);
         apb(1, OFS_IRQ_STAT, 32'hc, 0);
      end
      $display("update test done");
      results();
   end
endmodule : uplink_lane_select_health_bench
